/* design/adc_cfg_pkg.sv */
package adc_cfg_pkg;
  // Serial frame: read flag, address, data byte, most significant bit first
  localparam int FRAME_BITS = 24;
  localparam int HDR_BITS = 16;
  localparam int ADDR_BITS = 15;
  localparam int DATA_BITS = 8;
  localparam int SCLK_HALF_CYCLES = 4;

  localparam logic [14:0] ADDR_DELAY_SEL = 15'h0029;
  localparam logic [14:0] ADDR_EDGE_POS0 = 15'h002C;
  localparam logic [14:0] ADDR_EDGE_POS1 = 15'h002D;
  localparam logic [14:0] ADDR_EDGE_POS2 = 15'h002E;
  localparam logic [14:0] ADDR_FS_LO = 15'h0030;
  localparam logic [14:0] ADDR_FS_HI = 15'h0031;
  localparam logic [14:0] ADDR_POWER_MODE = 15'h0037;
  localparam logic [14:0] ADDR_POWER_LAST = 15'h003A;
  localparam logic [14:0] ADDR_TIMESTAMP = 15'h003B;
  localparam logic [14:0] ADDR_REFOUT = 15'h003C;

  localparam logic [3:0] RST_DELAY_SEL = 4'h0;
  localparam logic [23:0] RST_EDGE_POS = 24'h000000;
  localparam logic [15:0] RST_FULL_SCALE = 16'hA000;
  localparam logic [7:0] RST_POWER_MODE = 8'h4B;
  localparam logic RST_TS_RECV = 1'b0;
  localparam logic RST_TS_PECL = 1'b0;
  localparam logic RST_REFOUT_EN = 1'b1;

  localparam int TS_RECV_BIT = 0;
  localparam int TS_PECL_BIT = 1;
  localparam int REFOUT_EN_BIT = 0;
  localparam logic [7:0] MASK_TIMESTAMP = 8'h03;
  localparam logic [7:0] MASK_REFOUT = 8'h01;

  localparam logic [7:0] POWER_LOW = 8'h46;
  localparam logic [7:0] POWER_HIGH = 8'h4B;
  localparam logic [15:0] FS_MIN_GOOD = 16'h2000;
  localparam logic [15:0] FS_MAX = 16'hFFFF;

  // Host register file, byte addresses on the Avalon side
  localparam logic [3:0] HREG_COMMAND = 4'h0;
  localparam logic [3:0] HREG_WDATA = 4'h4;
  localparam logic [3:0] HREG_CONDITIONS = 4'h8;
  localparam logic [3:0] HREG_STATUS = 4'hC;
  localparam int CMD_READ_BIT = 15;
  localparam int CMD_GROUP_BIT = 16;
  localparam int COND_RATE_BIT = 0;
  localparam int COND_QUIET_BIT = 1;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_REFUSED_BIT = 1;
  localparam int ST_CAL_BIT = 2;
  localparam int ST_RDATA_LSB = 8;
  localparam int GROUP_FRAMES = 4;
endpackage : adc_cfg_pkg

/* design/cfg_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface cfg_link_if;
  logic sclk;
  logic csn_n;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;
  // Weak pull-up on the return line while the device is not driving
  assign miso = miso_oe ? miso_o : 1'b1;
  modport host (output sclk, output csn_n, output mosi, input miso);
  modport dev (input sclk, input csn_n, input mosi, output miso_o, output miso_oe);
endinterface : cfg_link_if
`default_nettype wire

/* design/serial_frame_receiver.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_frame_receiver (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_sclk,
  input wire logic i_csn_n,
  input wire logic i_mosi,
  input wire logic [7:0] i_rdata,
  output logic o_miso,
  output logic o_miso_oe,
  output logic [14:0] o_addr,
  output logic o_hdr_pulse,
  output logic o_is_read,
  output logic o_wr_pulse,
  output logic [7:0] o_wdata
);
  logic sclk_q;
  logic [4:0] bit_cnt;
  logic [23:0] rx;
  logic [15:0] header;
  logic [7:0] tx;
  logic rise;
  logic fall;

  assign rise = i_sclk && !sclk_q && !i_csn_n;
  assign fall = !i_sclk && sclk_q && !i_csn_n;
  assign o_addr = header[14:0];
  assign o_is_read = header[15];

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sclk_q <= 1'b0;
      bit_cnt <= 5'h00;
      rx <= 24'h000000;
      header <= 16'h0000;
      o_hdr_pulse <= 1'b0;
      o_wr_pulse <= 1'b0;
      o_wdata <= 8'h00;
    end
    else
    begin
      sclk_q <= i_sclk;
      o_hdr_pulse <= 1'b0;
      o_wr_pulse <= 1'b0;
      if (i_csn_n)
      begin
        bit_cnt <= 5'h00;
        header <= 16'h0000;
      end
      else if (rise)
      begin
        rx <= {rx[22:0], i_mosi};
        bit_cnt <= bit_cnt + 5'h01;
        if (bit_cnt == 5'(adc_cfg_pkg::HDR_BITS - 1))
        begin
          header <= {rx[14:0], i_mosi};
          o_hdr_pulse <= 1'b1;
        end
        if (bit_cnt == 5'(adc_cfg_pkg::FRAME_BITS - 1))
        begin
          o_wr_pulse <= !header[15];
          o_wdata <= {rx[6:0], i_mosi};
        end
      end
    end
  end

  // Read data leaves on falling edges so the host can sample on rising ones
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      tx <= 8'h00;
      o_miso <= 1'b0;
      o_miso_oe <= 1'b0;
    end
    else
    begin
      o_miso_oe <= !i_csn_n && header[15] && (bit_cnt >= 5'(adc_cfg_pkg::HDR_BITS));
      if (fall && header[15])
      begin
        if (bit_cnt == 5'(adc_cfg_pkg::HDR_BITS))
        begin
          o_miso <= i_rdata[7];
          tx <= {i_rdata[6:0], 1'b0};
        end
        else
        begin
          o_miso <= tx[7];
          tx <= {tx[6:0], 1'b0};
        end
      end
    end
  end
endmodule : serial_frame_receiver
`default_nettype wire

/* design/adc_config_regs.sv */
// Overview of operation
// - Read-only 24-bit edge position status
// - Host uses edge position to pick delay
// - Four-bit capture delay select, bits 3:0
// - One full-scale code, reset 0xA000
// - Host avoids full-scale codes below 0x2000
// - Code 0xFFFF selects maximum range
// - Power code 0x46 low, 0x4B high
// - Low-power code only at 1 GSPS or less
// - Calibrate after any power mode change
// - Calibration and link disabled before power write
// - Timestamp receiver enable bit 0, reset 0
// - Timestamp PECL mode bit 1, reset 0
// - Reference output needs enable and PLL
// - Reference output enable resets to one
// - Host writes reserved bits as zero; delay select bits 7:4 go out unmasked
`timescale 1ns/1ps
`default_nettype none
module adc_config_regs (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  cfg_link_if.dev link,
  input wire logic [23:0] i_edge_position,
  input wire logic i_pll_enable,
  output logic [3:0] o_capture_delay_select,
  output logic [15:0] o_full_scale_code,
  output logic o_full_scale_max,
  output logic o_full_scale_degraded,
  output logic o_low_power_mode,
  output logic o_high_perf_mode,
  output logic o_power_mode_reserved,
  output logic o_timestamp_receiver_enable,
  output logic o_timestamp_pecl_mode,
  output logic o_pll_reference_output
);
  logic [23:0] sysref_edge_position;
  logic [23:0] edge_hold;
  logic [3:0] capture_delay_select;
  logic [15:0] full_scale_range;
  logic [7:0] fs_low_stage;
  logic [7:0] power_mode_primary;
  logic [1:0] timestamp_input_control;
  logic pll_refout_control;
  logic [14:0] addr;
  logic hdr_pulse;
  logic is_read;
  logic wr_pulse;
  logic [7:0] wdata;
  logic [7:0] rdata;

  serial_frame_receiver u_rx (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_sclk(link.sclk),
    .i_csn_n(link.csn_n),
    .i_mosi(link.mosi),
    .i_rdata(rdata),
    .o_miso(link.miso_o),
    .o_miso_oe(link.miso_oe),
    .o_addr(addr),
    .o_hdr_pulse(hdr_pulse),
    .o_is_read(is_read),
    .o_wr_pulse(wr_pulse),
    .o_wdata(wdata)
  );

  // Status capture runs every cycle; serial writes never reach it
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sysref_edge_position <= adc_cfg_pkg::RST_EDGE_POS;
    end
    else
    begin
      sysref_edge_position <= i_edge_position;
    end
  end

  // The three status bytes travel in separate frames; a read of the lowest
  // byte freezes the word so the upper bytes belong to the same capture
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      edge_hold <= adc_cfg_pkg::RST_EDGE_POS;
    end
    else if (hdr_pulse && is_read && addr == adc_cfg_pkg::ADDR_EDGE_POS0)
    begin
      edge_hold <= sysref_edge_position;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      capture_delay_select <= adc_cfg_pkg::RST_DELAY_SEL;
    end
    else if (wr_pulse && addr == adc_cfg_pkg::ADDR_DELAY_SEL)
    begin
      capture_delay_select <= wdata[3:0];
    end
  end

  // Low byte is staged and applied with the high byte, so the range never
  // passes through a half-updated code
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      fs_low_stage <= adc_cfg_pkg::RST_FULL_SCALE[7:0];
      full_scale_range <= adc_cfg_pkg::RST_FULL_SCALE;
    end
    else if (wr_pulse && addr == adc_cfg_pkg::ADDR_FS_LO)
    begin
      fs_low_stage <= wdata;
    end
    else if (wr_pulse && addr == adc_cfg_pkg::ADDR_FS_HI)
    begin
      full_scale_range <= {wdata, fs_low_stage};
    end
  end

  // Any code is stored; reserved codes are flagged, not corrected
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      power_mode_primary <= adc_cfg_pkg::RST_POWER_MODE;
    end
    else if (wr_pulse && addr == adc_cfg_pkg::ADDR_POWER_MODE)
    begin
      power_mode_primary <= wdata;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      timestamp_input_control[adc_cfg_pkg::TS_RECV_BIT] <= adc_cfg_pkg::RST_TS_RECV;
      timestamp_input_control[adc_cfg_pkg::TS_PECL_BIT] <= adc_cfg_pkg::RST_TS_PECL;
    end
    else if (wr_pulse && addr == adc_cfg_pkg::ADDR_TIMESTAMP)
    begin
      timestamp_input_control[adc_cfg_pkg::TS_RECV_BIT] <= wdata[adc_cfg_pkg::TS_RECV_BIT];
      timestamp_input_control[adc_cfg_pkg::TS_PECL_BIT] <= wdata[adc_cfg_pkg::TS_PECL_BIT];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pll_refout_control <= adc_cfg_pkg::RST_REFOUT_EN;
    end
    else if (wr_pulse && addr == adc_cfg_pkg::ADDR_REFOUT)
    begin
      pll_refout_control <= wdata[adc_cfg_pkg::REFOUT_EN_BIT];
    end
  end

  // Read mux; reserved bits and unmapped addresses return zero
  always_comb
  begin
    rdata = 8'h00;
    case (addr)
      adc_cfg_pkg::ADDR_DELAY_SEL: rdata = {4'h0, capture_delay_select};
      adc_cfg_pkg::ADDR_EDGE_POS0: rdata = edge_hold[7:0];
      adc_cfg_pkg::ADDR_EDGE_POS1: rdata = edge_hold[15:8];
      adc_cfg_pkg::ADDR_EDGE_POS2: rdata = edge_hold[23:16];
      adc_cfg_pkg::ADDR_FS_LO: rdata = full_scale_range[7:0];
      adc_cfg_pkg::ADDR_FS_HI: rdata = full_scale_range[15:8];
      adc_cfg_pkg::ADDR_POWER_MODE: rdata = power_mode_primary;
      adc_cfg_pkg::ADDR_TIMESTAMP: rdata = {6'h00, timestamp_input_control};
      adc_cfg_pkg::ADDR_REFOUT: rdata = {7'h00, pll_refout_control};
      default: rdata = 8'h00;
    endcase
  end

  // Decoded outputs lag their register by one clock
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_capture_delay_select <= adc_cfg_pkg::RST_DELAY_SEL;
      o_full_scale_code <= adc_cfg_pkg::RST_FULL_SCALE;
      o_full_scale_max <= 1'b0;
      o_full_scale_degraded <= 1'b0;
      o_low_power_mode <= 1'b0;
      o_high_perf_mode <= 1'b1;
      o_power_mode_reserved <= 1'b0;
      o_timestamp_receiver_enable <= 1'b0;
      o_timestamp_pecl_mode <= 1'b0;
      o_pll_reference_output <= 1'b0;
    end
    else
    begin
      o_capture_delay_select <= capture_delay_select;
      o_full_scale_code <= full_scale_range;
      o_full_scale_max <= full_scale_range == adc_cfg_pkg::FS_MAX;
      o_full_scale_degraded <= full_scale_range < adc_cfg_pkg::FS_MIN_GOOD;
      o_low_power_mode <= power_mode_primary == adc_cfg_pkg::POWER_LOW;
      o_high_perf_mode <= power_mode_primary == adc_cfg_pkg::POWER_HIGH;
      o_power_mode_reserved <= power_mode_primary != adc_cfg_pkg::POWER_LOW
        && power_mode_primary != adc_cfg_pkg::POWER_HIGH;
      o_timestamp_receiver_enable <= timestamp_input_control[adc_cfg_pkg::TS_RECV_BIT];
      o_timestamp_pecl_mode <= timestamp_input_control[adc_cfg_pkg::TS_PECL_BIT];
      o_pll_reference_output <= pll_refout_control && i_pll_enable;
    end
  end
endmodule : adc_config_regs
`default_nettype wire

/* design/serial_config_host.sv */
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module serial_config_host #(
  parameter int SCLK_HALF = adc_cfg_pkg::SCLK_HALF_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  cfg_link_if.host link
);
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_GAP} link_state_type;

  if (SCLK_HALF < 2 || SCLK_HALF > 255)
  begin : g_bad_half
    $error("SCLK_HALF must lie in 2..255");
  end

  link_state_type state;
  logic [7:0] div_cnt;
  logic tick;
  logic [4:0] bit_cnt;
  logic [23:0] shreg;
  logic [7:0] rx;
  logic [7:0] rdata;
  logic is_read;
  logic is_group;
  logic [1:0] frame_idx;
  logic [31:0] wdata_reg;
  logic [1:0] conditions;
  logic refused;
  logic cal_required;
  logic rd_ack;
  logic cmd_write;
  logic cmd_go;
  logic refuse;
  logic group_done;
  logic [14:0] cmd_addr;
  logic [7:0] cmd_byte;
  logic [14:0] next_group_addr;

  // Reserved bits of the timestamp and reference output registers always go out as zero
  function automatic logic [7:0] mask_reserved(input logic [14:0] a, input logic [7:0] d);
    if (a == adc_cfg_pkg::ADDR_TIMESTAMP)
      return d & adc_cfg_pkg::MASK_TIMESTAMP;
    else if (a == adc_cfg_pkg::ADDR_REFOUT)
      return d & adc_cfg_pkg::MASK_REFOUT;
    else
      return d;
  endfunction : mask_reserved

  assign cmd_addr = i_writedata[14:0];
  assign cmd_byte = wdata_reg[7:0];
  assign cmd_write = i_write && i_address == adc_cfg_pkg::HREG_COMMAND;
  assign cmd_go = cmd_write && state == ST_IDLE;
  // A command while a transfer runs stalls the bus instead of being lost
  assign o_waitrequest = (i_read && !rd_ack) || (cmd_write && state != ST_IDLE);
  assign tick = div_cnt == 8'(SCLK_HALF - 1);
  assign next_group_addr = adc_cfg_pkg::ADDR_POWER_MODE + {13'h0000, frame_idx} + 15'h0001;
  assign group_done = state == ST_GAP && tick && is_group
    && frame_idx == 2'(adc_cfg_pkg::GROUP_FRAMES - 1);

  always_comb
  begin
    refuse = 1'b0;
    if (i_writedata[adc_cfg_pkg::CMD_GROUP_BIT])
      refuse = !conditions[adc_cfg_pkg::COND_QUIET_BIT]
        || (cmd_byte != adc_cfg_pkg::POWER_LOW && cmd_byte != adc_cfg_pkg::POWER_HIGH)
        || (cmd_byte == adc_cfg_pkg::POWER_LOW && !conditions[adc_cfg_pkg::COND_RATE_BIT]);
    else if (!i_writedata[adc_cfg_pkg::CMD_READ_BIT])
      refuse = (cmd_addr >= adc_cfg_pkg::ADDR_POWER_MODE && cmd_addr <= adc_cfg_pkg::ADDR_POWER_LAST)
        || (cmd_addr == adc_cfg_pkg::ADDR_FS_HI && cmd_byte < adc_cfg_pkg::FS_MIN_GOOD[15:8]);
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wdata_reg <= 32'h00000000;
      conditions <= 2'h0;
    end
    else if (i_write && i_address == adc_cfg_pkg::HREG_WDATA)
      wdata_reg <= i_writedata;
    else if (i_write && i_address == adc_cfg_pkg::HREG_CONDITIONS)
      conditions <= i_writedata[1:0];
  end

  // Sticky flags: hardware set wins over a same-cycle write-one-to-clear
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      refused <= 1'b0;
      cal_required <= 1'b0;
    end
    else
    begin
      if (cmd_go && refuse)
        refused <= 1'b1;
      else if (i_write && i_address == adc_cfg_pkg::HREG_STATUS && i_writedata[adc_cfg_pkg::ST_REFUSED_BIT])
        refused <= 1'b0;
      if (group_done)
        cal_required <= 1'b1;
      else if (i_write && i_address == adc_cfg_pkg::HREG_STATUS && i_writedata[adc_cfg_pkg::ST_CAL_BIT])
        cal_required <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rd_ack <= 1'b0;
      o_readdata <= 32'h00000000;
    end
    else
    begin
      rd_ack <= i_read && !rd_ack;
      if (i_read && !rd_ack)
      begin
        case (i_address)
          adc_cfg_pkg::HREG_WDATA: o_readdata <= wdata_reg;
          adc_cfg_pkg::HREG_CONDITIONS: o_readdata <= {30'h00000000, conditions};
          adc_cfg_pkg::HREG_STATUS: o_readdata <= {16'h0000, rdata, 5'h00, cal_required, refused, state != ST_IDLE};
          default: o_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      div_cnt <= 8'h00;
    else if (state == ST_IDLE || tick)
      div_cnt <= 8'h00;
    else
      div_cnt <= div_cnt + 8'h01;
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state <= ST_IDLE;
      link.sclk <= 1'b0;
      link.csn_n <= 1'b1;
      link.mosi <= 1'b0;
      shreg <= 24'h000000;
      bit_cnt <= 5'h00;
      rx <= 8'h00;
      rdata <= 8'h00;
      is_read <= 1'b0;
      is_group <= 1'b0;
      frame_idx <= 2'h0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (cmd_go && !refuse)
          begin
            is_read <= i_writedata[adc_cfg_pkg::CMD_READ_BIT] && !i_writedata[adc_cfg_pkg::CMD_GROUP_BIT];
            is_group <= i_writedata[adc_cfg_pkg::CMD_GROUP_BIT];
            frame_idx <= 2'h0;
            bit_cnt <= 5'h00;
            link.csn_n <= 1'b0;
            if (i_writedata[adc_cfg_pkg::CMD_GROUP_BIT])
            begin
              shreg <= {1'b0, adc_cfg_pkg::ADDR_POWER_MODE, cmd_byte};
              link.mosi <= 1'b0;
            end
            else
            begin
              shreg <= {i_writedata[adc_cfg_pkg::CMD_READ_BIT], cmd_addr, mask_reserved(cmd_addr, cmd_byte)};
              link.mosi <= i_writedata[adc_cfg_pkg::CMD_READ_BIT];
            end
            state <= ST_SHIFT;
          end
        end
        ST_SHIFT:
        begin
          if (tick && !link.sclk)
          begin
            link.sclk <= 1'b1;
            rx <= {rx[6:0], link.miso};
            bit_cnt <= bit_cnt + 5'h01;
          end
          else if (tick)
          begin
            link.sclk <= 1'b0;
            if (bit_cnt == 5'(adc_cfg_pkg::FRAME_BITS))
            begin
              link.csn_n <= 1'b1;
              if (is_read)
                rdata <= rx;
              state <= ST_GAP;
            end
            else
            begin
              link.mosi <= shreg[22];
              shreg <= {shreg[22:0], 1'b0};
            end
          end
        end
        ST_GAP:
        begin
          if (tick && is_group && frame_idx != 2'(adc_cfg_pkg::GROUP_FRAMES - 1))
          begin
            frame_idx <= frame_idx + 2'h1;
            shreg <= {1'b0, next_group_addr, wdata_reg[8 * (frame_idx + 2'h1) +: 8]};
            link.mosi <= 1'b0;
            link.csn_n <= 1'b0;
            bit_cnt <= 5'h00;
            state <= ST_SHIFT;
          end
          else if (tick)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule : serial_config_host
`default_nettype wire

/* sim/adc_config_status_regs_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_config_status_regs_asserts #(
  parameter int SCLK_HALF = adc_cfg_pkg::SCLK_HALF_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic sclk,
  input wire logic csn_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic i_pll_enable,
  input wire logic o_pll_reference_output,
  input wire logic [15:0] o_full_scale_code,
  input wire logic o_full_scale_max,
  input wire logic o_low_power_mode,
  input wire logic o_high_perf_mode,
  input wire logic o_power_mode_reserved
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  logic [7:0] hi_cnt;
  logic [5:0] rises;
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      hi_cnt <= 8'h00;
    else
      hi_cnt <= sclk ? hi_cnt + 8'h01 : 8'h00;
  end
  // Rises are counted per frame so a dropped or extra bit shows at frame end
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      rises <= 6'h00;
    else
      rises <= csn_n ? 6'h00 : rises + {5'h00, sclk && hi_cnt == 8'h00};
  end
  a_half_period: assert property ($fell(sclk) |-> hi_cnt == 8'(SCLK_HALF))
    else $error("serial clock high phase has wrong length");
  a_frame_bits: assert property ($rose(csn_n) |-> rises == 6'h18)
    else $error("frame did not carry 24 bits");
  a_idle_clock: assert property (csn_n |-> !sclk)
    else $error("serial clock runs outside a frame");
  a_mosi_hold: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("command line moved while clock high");
  // Gap is a fixed figure because the bench runs the host at half period 2
  a_frame_gap: assert property ($rose(csn_n) |-> csn_n [*2])
    else $error("frames too close together");
  a_miso_release: assert property (csn_n && $past(csn_n) |-> !miso_oe)
    else $error("device drives return line when not selected");
  a_miso_hold: assert property (sclk && $past(sclk) && $past(miso_oe) |-> $stable(miso))
    else $error("return line moved while clock high");
  a_refout_gate: assert property (!$past(i_pll_enable) |-> !o_pll_reference_output)
    else $error("reference output active with pll off");
  a_fs_max: assert property (o_full_scale_max == (o_full_scale_code == 16'hFFFF))
    else $error("maximum range flag does not match code");
  a_power_decode: assert property ($onehot({o_low_power_mode, o_high_perf_mode, o_power_mode_reserved}))
    else $error("power mode decode not one hot");
endmodule : adc_config_status_regs_asserts
`default_nettype wire

/* sim/adc_config_status_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_config_status_regs_tb;
  localparam int HALF = 2;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] addr;
  logic rd, wr, pll, wt;
  logic [31:0] wd, rq, r;
  logic [23:0] epos;
  logic [3:0] dly;
  logic [15:0] fs;
  logic fmax, fdeg, lp, hp, pres, tsr, tsp, refo;
  logic [14:0] ra [8] = '{15'h2C, 15'h2D, 15'h2E, 15'h30, 15'h31, 15'h37, 15'h3B, 15'h3C};
  logic [7:0] rv [8] = '{8'h96, 8'h3C, 8'h5A, 8'h00, 8'hA0, 8'h4B, 8'h00, 8'h01};
  int error_cnt = 0;
  int checked = 0;
  always #10 sys_clk = ~sys_clk;
  cfg_link_if i_cfg_link_if();
  serial_config_host #(.SCLK_HALF(HALF)) i_serial_config_host (.i_sys_clk(sys_clk), .i_nrst(nrst),
    .i_address(addr), .i_read(rd), .i_write(wr), .i_writedata(wd), .o_readdata(rq),
    .o_waitrequest(wt), .link(i_cfg_link_if.host));
  adc_config_regs i_adc_config_regs (.i_sys_clk(sys_clk), .i_nrst(nrst), .link(i_cfg_link_if.dev),
    .i_edge_position(epos), .i_pll_enable(pll), .o_capture_delay_select(dly),
    .o_full_scale_code(fs), .o_full_scale_max(fmax), .o_full_scale_degraded(fdeg),
    .o_low_power_mode(lp), .o_high_perf_mode(hp), .o_power_mode_reserved(pres),
    .o_timestamp_receiver_enable(tsr), .o_timestamp_pecl_mode(tsp), .o_pll_reference_output(refo));
  adc_config_status_regs_asserts #(.SCLK_HALF(HALF)) i_adc_config_status_regs_asserts (.i_sys_clk(sys_clk),
    .i_nrst(nrst),
    .sclk(i_cfg_link_if.sclk), .csn_n(i_cfg_link_if.csn_n), .mosi(i_cfg_link_if.mosi),
    .miso(i_cfg_link_if.miso), .miso_oe(i_cfg_link_if.miso_oe), .i_pll_enable(pll),
    .o_pll_reference_output(refo), .o_full_scale_code(fs), .o_full_scale_max(fmax),
    .o_low_power_mode(lp), .o_high_perf_mode(hp), .o_power_mode_reserved(pres));

  task complete_run();
    $display("error_cnt=%0d checked=%0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  task to();
    error_cnt++;
    $display("BAD %0t wait limit reached", $time);
    complete_run();
  endtask : to

  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task chk_bit(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask : chk_bit

  // The request stands until the rising edge that samples waitrequest low;
  // read data is taken at that same edge and only then is the request dropped
  task av(input logic [3:0] a, input logic rdn, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    addr <= a;
    rd <= rdn;
    wr <= !rdn;
    wd <= d;
    @(posedge sys_clk);
    while (wt !== 1'b0)
    begin
      n++;
      if (n > 2000)
        to();
      @(posedge sys_clk);
    end
    r = rq;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : av

  task cmd(input logic [16:0] c, input logic [31:0] d);
    int n;
    n = 0;
    av(4'hC, 1'b0, 32'h6);
    av(4'h4, 1'b0, d);
    av(4'h0, 1'b0, {15'h0, c});
    r = 32'h1;
    while (r[0] !== 1'b0)
    begin
      n++;
      if (n > 900)
        to();
      av(4'hC, 1'b1, 32'h0);
    end
  endtask : cmd

  task dw(input logic [14:0] a, input logic [7:0] b);
    cmd({2'b00, a}, {24'h0, b});
  endtask : dw

  task dr(input logic [14:0] a, input logic [7:0] e);
    cmd({2'b01, a}, 32'h0);
    chk({24'h0, r[15:8]}, {24'h0, e});
  endtask : dr

  initial
  begin
    addr = 4'h0;
    rd = 1'b0;
    wr = 1'b0;
    wd = 32'h0;
    epos = 24'h5A3C96;
    pll = 1'b1;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(negedge sys_clk);
    chk({16'h0, fs}, 32'hA000);
    chk({30'h0, tsp, tsr}, 32'h0);
    chk({30'h0, refo, hp}, 32'h3);
    for (int i = 0; i < 8; i++)
      dr(ra[i], rv[i]);
    dw(15'h2C, 8'hFF);
    dr(15'h2C, 8'h96);
    dw(15'h29, r[15:8]);
    chk({28'h0, dly}, 32'h6);
    dw(15'h30, 8'hFF);
    dw(15'h31, 8'hFF);
    chk({15'h0, fmax, fs}, 32'h1FFFF);
    dw(15'h31, 8'h1F);
    chk({14'h0, r[1], fmax, fs}, 32'h3FFFF);
    dw(15'h30, 8'h00);
    dw(15'h31, 8'h20);
    chk({15'h0, fdeg, fs}, 32'h2000);
    dw(15'h3B, 8'hFF);
    chk({30'h0, tsp, tsr}, 32'h3);
    dr(15'h3B, 8'h03);
    dw(15'h3B, 8'h02);
    chk({30'h0, tsp, tsr}, 32'h2);
    dw(15'h3C, 8'hFE);
    chk_bit(refo, 1'b0);
    dr(15'h3C, 8'h00);
    dw(15'h3C, 8'h01);
    chk_bit(refo, 1'b1);
    @(posedge sys_clk);
    pll <= 1'b0;
    repeat (2) @(negedge sys_clk);
    chk_bit(refo, 1'b0);
    @(posedge sys_clk);
    pll <= 1'b1;
    dw(15'h37, 8'h46);
    chk_bit(r[1] & hp, 1'b1);
    av(4'h8, 1'b0, 32'h0);
    cmd(17'h10037, 32'h46);
    chk_bit(r[1] & hp, 1'b1);
    av(4'h8, 1'b0, 32'h2);
    cmd(17'h10037, 32'h46);
    chk_bit(r[1] & hp, 1'b1);
    av(4'h8, 1'b0, 32'h3);
    cmd(17'h10037, 32'h46);
    chk({28'h0, r[2:1], lp, hp}, 32'hA);
    chk_bit(pres, 1'b0);
    dr(15'h37, 8'h46);
    cmd(17'h10037, 32'h4B);
    chk({30'h0, lp, hp}, 32'h1);
    av(4'h2, 1'b1, 32'h0);
    chk(r, 32'h0);
    complete_run();
  end
endmodule : adc_config_status_regs_tb
`default_nettype wire
